// [rtl/eerw_cfg.svh]
`ifndef EERW_CFG_SVH
`define EERW_CFG_SVH
// I/O-space register offsets
`define EERW_OFS_CONTROL   6'h1c
`define EERW_OFS_DATA      6'h1d
`define EERW_OFS_ADDRESS   6'h1e
// Control register bit positions
`define EERW_BIT_READ      0
`define EERW_BIT_WRITE     1
`define EERW_BIT_ARM       2
`define EERW_BIT_RIE       3
// Reset value of the control register
`define EERW_CTRL_RESET    4'h0
// Timing
`define EERW_CLK_HZ        50000000
`define EERW_WRITE_US      4000
`define EERW_WRITE_CYCLES  ((`EERW_WRITE_US * (`EERW_CLK_HZ / 1000000)))
`define EERW_ARM_CYCLES    3'h4
`define EERW_WR_HALT       3'h2
`define EERW_RD_HALT       3'h4
// Memory depth
`define EERW_DEPTH         256
`endif

// [rtl/eerw_ctrl.sv]
// Overview of operation
// - Write strobe held through timed write, then cleared
// - Ongoing write finishes despite reset
// - Write strobe halts CPU two cycles
// - Read strobe halts CPU four cycles
// - Address register selects byte linearly, unreset
// - Data register holds write byte, read result
// - Control bits seven to four read zero
// - Ready interrupt while write strobe reads zero
// - Write starts only when arm already set
// - Arm bit self-clears four cycles later
// - Read strobe fetches byte, self-clears
// - Address/data write aborts ongoing write
`timescale 1ns/1ps
`default_nettype none
`include "eerw_cfg.svh"
module eerw_ctrl (
    input  wire logic             CLOCK_IN,
    input  wire logic             RST_B_IN,
    input  wire logic [5:0]       IO_ADDR_IN,
    input  wire logic             IO_WR_IN,
    input  wire logic             IO_RD_IN,
    input  wire eerw_pkg::eerw_byte_t IO_WDATA_IN,
    input  wire logic             GLOBAL_IRQ_EN_IN,
    output logic [7:0]            IO_RDATA_OUT,
    output logic                  CPU_HALT_OUT,
    output logic                  READY_IRQ_OUT,
    output logic                  WRITE_ABORT_OUT
);
    import eerw_pkg::*;

    localparam int WR_CYC = `EERW_WRITE_CYCLES;    // Self-timed write length

    // Register state
    logic [7:0]  addr_q, addr_d;                   // Address, no reset
    logic [7:0]  data_q, data_d;                   // Data, no reset
    logic        rie_q, rie_d;                     // Ready irq enable
    logic        arm_q, arm_d;                     // Master write arm
    logic [2:0]  arm_cnt_q, arm_cnt_d;             // Arm timeout count
    logic        rd_q, rd_d;                       // Read strobe
    logic [2:0]  halt_q, halt_d;                   // CPU halt count
    logic        halt_out_q, halt_out_d;           // Registered stall level
    logic        rd_pend_q, rd_pend_d;             // Memory read in flight
    logic [7:0]  rdata_q, rdata_d;                 // Read mux register
    logic        irq_q, irq_d;                     // Interrupt output
    logic        abort_q, abort_d;                 // Abort pulse
    // Write engine, never reset
    eerw_state_t st_q, st_d;                       // Engine state
    logic [17:0] wcnt_q, wcnt_d;                   // Write timer
    logic        mem_we;                           // Commit strobe to array
    logic [7:0]  mem_rdata;                        // Array read data
    logic [7:0]  ctrl_rd;                          // Control read view

    // Decoded accesses
    wire wr_ctl  = IO_WR_IN && (IO_ADDR_IN == `EERW_OFS_CONTROL);
    wire wr_dat  = IO_WR_IN && (IO_ADDR_IN == `EERW_OFS_DATA);
    wire wr_adr  = IO_WR_IN && (IO_ADDR_IN == `EERW_OFS_ADDRESS);
    wire busy    = (st_q == EERW_BUSY);
    wire wr_go   = wr_ctl && IO_WDATA_IN[`EERW_BIT_WRITE] && arm_q && !busy;

    // Control view, upper nibble zero
    always_comb begin
        ctrl_rd = {4'h0, rie_q, arm_q, busy, rd_q};
    end

    // Register file and strobe handling
    always_comb begin
        addr_d    = addr_q;
        data_d    = data_q;
        rie_d     = rie_q;
        arm_d     = arm_q;
        arm_cnt_d = arm_cnt_q;
        rd_d      = rd_q;
        halt_d    = (halt_q != 3'h0) ? halt_q - 3'h1 : 3'h0;
        rd_pend_d = 1'b0;
        // Plain register loads from the CPU
        if (wr_adr) begin
            addr_d = IO_WDATA_IN;
        end
        if (wr_dat) begin
            data_d = IO_WDATA_IN;
        end
        // Arm timeout
        if (arm_q) begin
            arm_cnt_d = arm_cnt_q - 3'h1;
            if (arm_cnt_q == 3'h1) begin
                arm_d = 1'b0;
            end
        end
        // Control write: enable, arm and strobes
        if (wr_ctl) begin
            rie_d = IO_WDATA_IN[`EERW_BIT_RIE];
            if (IO_WDATA_IN[`EERW_BIT_ARM]) begin
                arm_d     = 1'b1;
                arm_cnt_d = `EERW_ARM_CYCLES;
            end
            // Read strobe: fetch and halt
            if (IO_WDATA_IN[`EERW_BIT_READ] && !busy) begin
                rd_d      = 1'b1;
                rd_pend_d = 1'b1;
                halt_d    = `EERW_RD_HALT;
            end else if (wr_go) begin
                halt_d = `EERW_WR_HALT;
            end
        end
        // Array data lands, strobe drops
        if (rd_pend_q) begin
            data_d = mem_rdata;
            rd_d   = 1'b0;
        end
    end

    // Write engine next state
    always_comb begin
        st_d    = st_q;
        wcnt_d  = wcnt_q;
        mem_we  = 1'b0;
        abort_d = 1'b0;
        unique case (st_q)
            EERW_IDLE: begin
                // Armed strobe launches the timed write
                if (wr_go) begin
                    st_d   = EERW_BUSY;
                    wcnt_d = 18'(WR_CYC - 1);
                end
            end
            EERW_BUSY: begin
                // Address or data touched mid-write: give up
                if (wr_adr || wr_dat) begin
                    st_d    = EERW_IDLE;
                    abort_d = 1'b1;
                end else if (wcnt_q == 18'h0) begin
                    // Timer expired: commit byte, strobe drops
                    st_d   = EERW_IDLE;
                    mem_we = 1'b1;
                end else begin
                    // Count down the self-timed period
                    wcnt_d = wcnt_q - 18'h1;
                end
            end
            // Unknown code after power-up falls back to idle
            default: begin
                st_d = EERW_IDLE;
            end
        endcase
    end

    // Outputs next values
    always_comb begin
        rdata_d = 8'h00;
        unique case (IO_ADDR_IN)
            `EERW_OFS_CONTROL: rdata_d = ctrl_rd;
            `EERW_OFS_DATA:    rdata_d = data_q;
            `EERW_OFS_ADDRESS: rdata_d = addr_q;
            default:           rdata_d = 8'h00;
        endcase
        irq_d = rie_q && GLOBAL_IRQ_EN_IN && !busy;
        // Stall stays high while the count is nonzero
        halt_out_d = (halt_d != 3'h0);
    end

    // Resettable control registers
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            // Control state returns to its defaults
            rie_q     <= 1'b0;
            halt_out_q <= 1'b0;
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
            rd_q      <= 1'b0;
            halt_q    <= 3'h0;
            rd_pend_q <= 1'b0;
            rdata_q   <= 8'h00;
            irq_q     <= 1'b0;
            abort_q   <= 1'b0;
        end else begin
            // Normal update from next-state logic
            rie_q     <= rie_d;
            halt_out_q <= halt_out_d;
            arm_q     <= arm_d;
            arm_cnt_q <= arm_cnt_d;
            rd_q      <= rd_d;
            halt_q    <= halt_d;
            rd_pend_q <= rd_pend_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            abort_q   <= abort_d;
        end
    end

    // Unreset registers: address, data and write engine
    // Reset must not reach here: a started write has to finish
    always_ff @(posedge CLOCK_IN) begin
        addr_q <= addr_d;
        data_q <= data_d;
        st_q   <= (st_d == EERW_BUSY) ? EERW_BUSY : EERW_IDLE;
        wcnt_q <= wcnt_d;
    end

    // Top outputs straight from registers
    always_comb begin
        CPU_HALT_OUT    = halt_out_q;
        IO_RDATA_OUT    = rdata_q;
        READY_IRQ_OUT   = irq_q;
        WRITE_ABORT_OUT = abort_q;
    end

    // Nonvolatile array
    // Read port follows the address register so a strobe sees fresh data
    eerw_mem u_mem (
        .clk_in      (CLOCK_IN),
        .wr_en_in    (mem_we),
        .wr_addr_in  (addr_q),
        .wr_data_in  (data_q),
        .rd_addr_in  (addr_q),
        .rd_data_out (mem_rdata)
    );
endmodule : eerw_ctrl
`default_nettype wire

// [rtl/eerw_mem.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eerw_cfg.svh"
module eerw_mem (
    input  wire logic       clk_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] rd_addr_in,
    output logic      [7:0] rd_data_out
);
    // Byte array, no reset: contents are nonvolatile
    logic [7:0] mem_q [0:`EERW_DEPTH-1];

    // Write port
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read port
    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule : eerw_mem
`default_nettype wire

// [rtl/eerw_pkg.sv]
package eerw_pkg;
    // Write engine states
    typedef enum logic [1:0] {
        EERW_IDLE = 2'b01,
        EERW_BUSY = 2'b10
    } eerw_state_t;
    typedef logic [7:0] eerw_byte_t;
endpackage : eerw_pkg

// [tb/eerw_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eerw_cpu_model (
    input  wire logic           clk_in,
    input  wire logic           halt_in,
    input  wire logic [7:0]     rdata_in,
    output logic      [5:0]     addr_out,
    output logic                wr_out,
    output logic                rd_out,
    output eerw_pkg::eerw_byte_t wdata_out
);
    import eerw_pkg::*;
    initial begin
        addr_out = 6'h00; wr_out = 1'b0; rd_out = 1'b0; wdata_out = 8'h00;
    end
    // One-cycle I/O write; no issue while stalled; counts stall cycles after
    task io_write(input logic [5:0] a, input logic [7:0] d, output int halts);
        halts = 0;
        @(negedge clk_in);
        while (halt_in === 1'b1) @(negedge clk_in);
        addr_out = a; wdata_out = d; wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0; wdata_out = ~d; addr_out = ~a; // Released bus shows inverse
        while (halt_in === 1'b1 && halts < 8) begin
            halts++;
            @(negedge clk_in);
        end
    endtask : io_write
    // Read data is registered one cycle after the address
    task io_read(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_in);
        while (halt_in === 1'b1) @(negedge clk_in);
        addr_out = a; rd_out = 1'b1;
        @(negedge clk_in);
        d = rdata_in; rd_out = 1'b0; addr_out = ~a;
    endtask : io_read
endmodule : eerw_cpu_model
`default_nettype wire

// [tb/eerw_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module eerw_ctrl_chk (
    input wire logic                 CLOCK_IN,
    input wire logic                 RST_B_IN,
    input wire logic [5:0]           IO_ADDR_IN,
    input wire logic                 IO_WR_IN,
    input wire eerw_pkg::eerw_byte_t IO_WDATA_IN,
    input wire logic                 GLOBAL_IRQ_EN_IN,
    input wire logic [7:0]           IO_RDATA_OUT,
    input wire logic                 CPU_HALT_OUT,
    input wire logic                 READY_IRQ_OUT,
    input wire logic                 WRITE_ABORT_OUT
);
    import eerw_pkg::*;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN);
    // Stall shapes of the two strobes
    sequence s_wr_halt; CPU_HALT_OUT [*2] ##1 !CPU_HALT_OUT; endsequence
    sequence s_rd_halt; CPU_HALT_OUT [*4] ##1 !CPU_HALT_OUT; endsequence
    AST_RSV_ZERO: assert property (IO_ADDR_IN == 6'h1c |=> IO_RDATA_OUT[7:4] == 4'h0)
        else $error("reserved control bits not zero");
    AST_HALT_LEN: assert property ($rose(CPU_HALT_OUT) |-> s_wr_halt or s_rd_halt)
        else $error("stall length wrong");
    AST_HALT_CAUSE: assert property ($rose(CPU_HALT_OUT) |-> $past(IO_WR_IN) || $past(IO_WR_IN, 2))
        else $error("stall without strobe");
    AST_ABORT_PULSE: assert property (WRITE_ABORT_OUT |=> !WRITE_ABORT_OUT)
        else $error("abort not a pulse");
    AST_ABORT_CAUSE: assert property ($rose(WRITE_ABORT_OUT) |->
        $past(IO_WR_IN && IO_ADDR_IN inside {6'h1d, 6'h1e}) ||
        $past(IO_WR_IN && IO_ADDR_IN inside {6'h1d, 6'h1e}, 2))
        else $error("abort without register write");
    AST_IRQ_GIE: assert property (!GLOBAL_IRQ_EN_IN |=> !READY_IRQ_OUT)
        else $error("ready request without global enable");
    AST_IRQ_RISE: assert property ($rose(READY_IRQ_OUT) |-> $past(GLOBAL_IRQ_EN_IN))
        else $error("ready request rose without global enable");
    AST_WR_BUSY_NO_IRQ: assert property ($fell(CPU_HALT_OUT) && $past(CPU_HALT_OUT, 2)
        && !$past(CPU_HALT_OUT, 3) |-> !READY_IRQ_OUT)
        else $error("ready request during write");
endmodule : eerw_ctrl_chk
bind eerw_ctrl eerw_ctrl_chk i_chk (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .IO_ADDR_IN(IO_ADDR_IN),
    .IO_WR_IN(IO_WR_IN), .IO_WDATA_IN(IO_WDATA_IN), .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN),
    .IO_RDATA_OUT(IO_RDATA_OUT), .CPU_HALT_OUT(CPU_HALT_OUT), .READY_IRQ_OUT(READY_IRQ_OUT),
    .WRITE_ABORT_OUT(WRITE_ABORT_OUT));
`default_nettype wire

// [tb/tb_eeprom_rw_access_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_rw_access_ctrl;
    import eerw_pkg::*;
    logic clk, rst_b, wr, rd, gie, halt, irq, abort;
    logic [5:0] addr;
    logic [7:0] rdata, v;
    eerw_byte_t wdata;
    int n_errors = 0, total_checks = 0, cyc = 0, h, n_abort = 0;
    eerw_ctrl i_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .IO_ADDR_IN(addr), .IO_WR_IN(wr), .IO_RD_IN(rd),
        .IO_WDATA_IN(wdata), .GLOBAL_IRQ_EN_IN(gie), .IO_RDATA_OUT(rdata), .CPU_HALT_OUT(halt),
        .READY_IRQ_OUT(irq), .WRITE_ABORT_OUT(abort));
    eerw_cpu_model i_cpu (.clk_in(clk), .halt_in(halt), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Cycle ceiling and abort pulse counter
    always @(posedge clk) begin
        cyc++;
        if (abort === 1'b1) n_abort++;
        if (cyc == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish();
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Strobe without arm is ignored
    task t_no_arm();
        i_cpu.io_read(6'h1c, v); chk(v, 8'h00);
        i_cpu.io_write(6'h1e, 8'h05, h);
        i_cpu.io_write(6'h1c, 8'h02, h); chk(h[7:0], 8'h00);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h00);
    endtask : t_no_arm
    // Arm bit lapses after four cycles
    task t_arm_timeout();
        i_cpu.io_write(6'h1c, 8'h04, h);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h04);
        repeat (4) @(negedge clk);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h00);
    endtask : t_arm_timeout
    // Read strobe stalls four cycles and self-clears
    task t_read();
        i_cpu.io_write(6'h1c, 8'h01, h); chk(h[7:0], 8'h04);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h00);
        i_cpu.io_read(6'h1e, v); chk(v, 8'h05);
    endtask : t_read
    // Armed write, reset mid-write, then abort by data write
    task t_write_abort();
        gie = 1'b0;
        i_cpu.io_write(6'h1d, 8'h5a, h);
        i_cpu.io_read(6'h1d, v); chk(v, 8'h5a);
        i_cpu.io_write(6'h1c, 8'h0c, h);
        i_cpu.io_write(6'h1c, 8'h0a, h); chk(h[7:0], 8'h02);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h0a);
        gie = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        i_cpu.io_read(6'h1c, v); chk(v, 8'h02);
        i_cpu.io_write(6'h1c, 8'h08, h);
        i_cpu.io_write(6'h1d, 8'ha5, h);
        repeat (2) @(negedge clk);
        chk(n_abort[7:0], 8'h01);
        i_cpu.io_read(6'h1c, v); chk(v, 8'h08);
        chk({7'h00, irq}, 8'h01);
        gie = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
    endtask : t_write_abort
    initial begin
        rst_b = 1'b0;
        gie = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        t_no_arm();
        t_arm_timeout();
        t_read();
        t_write_abort();
        tally_and_finish();
    end
endmodule : tb_eeprom_rw_access_ctrl
`default_nettype wire
